//--- rtl/pmc_cap_regs.sv
module pmc_cap_regs (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CFG_RD,
  input wire logic CFG_WR,
  input wire logic [5:0] CFG_DW_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_ACK,
  output logic [1:0] FUNCTION_POWER_LEVEL
);

  logic [1:0] level;
  logic level_wr;
  logic [15:0] csr_value;
  logic [31:0] next_rdata;
  logic is_read;

  // write wins when both strobes are high
  assign is_read = CFG_RD && !CFG_WR;

  // only lane 0 of the csr dword stores
  assign level_wr = CFG_WR && (CFG_DW_ADDR == pmc_pkg::DW_CSR) && CFG_BE[pmc_pkg::LANE_CSR_LO];

  pmc_power_level u_level (
    .clk(CLK_SYS),
    .rst(RESET),
    .wr_en(level_wr),
    .wr_level(CFG_WDATA[pmc_pkg::POS_LEVEL_MSB:pmc_pkg::POS_LEVEL_LSB]),
    .function_power_level(level)
  );

  assign csr_value = pmc_pkg::RST_CSR | {14'h0000, level};

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (is_read) begin
      case (CFG_DW_ADDR)
        pmc_pkg::DW_PM_HEAD: begin
          next_rdata[7:0] = pmc_pkg::VAL_PM_CAP_ID;
          next_rdata[8 * pmc_pkg::LANE_PM_NEXT +: 8] = pmc_pkg::VAL_PM_NEXT;
        end
        pmc_pkg::DW_CSR: begin
          next_rdata[15:0] = csr_value;
          next_rdata[8 * pmc_pkg::LANE_BSE +: 8] = pmc_pkg::VAL_BSE;
          next_rdata[8 * pmc_pkg::LANE_PM_DATA +: 8] = pmc_pkg::VAL_PM_DATA;
        end
        pmc_pkg::DW_MSI_HEAD: begin
          next_rdata[8 * pmc_pkg::LANE_MSI_ID +: 8] = pmc_pkg::VAL_MSI_ID;
          next_rdata[8 * pmc_pkg::LANE_MSI_NEXT +: 8] = pmc_pkg::VAL_MSI_NEXT;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      CFG_RDATA <= 32'h0000_0000;
    end else begin
      CFG_RDATA <= next_rdata;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      CFG_ACK <= 1'b0;
    end else begin
      CFG_ACK <= CFG_RD || CFG_WR;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      FUNCTION_POWER_LEVEL <= pmc_pkg::RST_LEVEL;
    end else begin
      FUNCTION_POWER_LEVEL <= level;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  sequence s_csr_read;
    is_read && CFG_DW_ADDR == pmc_pkg::DW_CSR;
  endsequence

  sequence s_level_write;
    level_wr;
  endsequence

  sequence s_enable_set_write;
    CFG_WR && CFG_DW_ADDR == pmc_pkg::DW_CSR && CFG_BE[1] && CFG_WDATA[pmc_pkg::POS_EVENT_EN];
  endsequence

  sequence s_release_csr_read;
    $past(RESET) ##0 s_csr_read;
  endsequence

  sequence s_collision;
    CFG_WR && CFG_RD;
  endsequence

  property p_csr_reset_read;
    s_release_csr_read |=> CFG_ACK && CFG_RDATA[15:0] == 16'h0008;
  endproperty
  a_csr_reset_read: assert property (p_csr_reset_read) else $error("csr not 0008h after reset");

  property p_event_status_zero;
    s_csr_read |=> CFG_ACK && !CFG_RDATA[pmc_pkg::POS_EVENT_STAT];
  endproperty
  a_event_status_zero: assert property (p_event_status_zero) else $error("event status bit set");

  property p_data_fields_zero;
    s_csr_read |=> CFG_RDATA[14:9] == 6'h00;
  endproperty
  a_data_fields_zero: assert property (p_data_fields_zero) else $error("data scale or select nonzero");

  property p_enable_stays_zero;
    s_enable_set_write ##1 s_csr_read |=> !CFG_RDATA[pmc_pkg::POS_EVENT_EN];
  endproperty
  a_enable_stays_zero: assert property (p_enable_stays_zero) else $error("event enable became set");

  property p_reserved_zero;
    s_csr_read |=> CFG_RDATA[7:4] == 4'h0 && !CFG_RDATA[2];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved csr bits nonzero");

  property p_no_soft_reset_one;
    s_csr_read |=> CFG_RDATA[pmc_pkg::POS_NO_SOFT_RST];
  endproperty
  a_no_soft_reset_one: assert property (p_no_soft_reset_one) else $error("no soft reset bit clear");

  property p_level_readback;
    s_level_write ##1 s_csr_read |=> CFG_RDATA[1:0] == $past(CFG_WDATA[1:0], 2)
      && FUNCTION_POWER_LEVEL == CFG_RDATA[1:0];
  endproperty
  a_level_readback: assert property (p_level_readback) else $error("power level readback mismatch");

  property p_bse_data_zero;
    s_csr_read |=> CFG_RDATA[31:16] == 16'h0000;
  endproperty
  a_bse_data_zero: assert property (p_bse_data_zero) else $error("bridge ext or data nonzero");

  property p_msi_head;
    is_read && CFG_DW_ADDR == pmc_pkg::DW_MSI_HEAD |=> CFG_ACK && CFG_RDATA == 32'h0000_8005;
  endproperty
  a_msi_head: assert property (p_msi_head) else $error("msi id or next pointer wrong");

  property p_pm_next;
    is_read && CFG_DW_ADDR == pmc_pkg::DW_PM_HEAD |=> CFG_RDATA[15:8] == 8'h70;
  endproperty
  a_pm_next: assert property (p_pm_next) else $error("pm next pointer not 70h");

  property p_ro_write_harmless;
    CFG_WR && !level_wr |=> CFG_ACK ##0 $stable(level);
  endproperty
  a_ro_write_harmless: assert property (p_ro_write_harmless) else $error("read-only write changed state");

  property p_reset_outputs;
    $past(RESET) |-> !CFG_ACK && CFG_RDATA == 32'h0000_0000 && FUNCTION_POWER_LEVEL == pmc_pkg::RST_LEVEL;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared by reset");

  property p_ack_follows;
    CFG_RD || CFG_WR |=> CFG_ACK;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("access not acknowledged");

  property p_no_spurious_ack;
    !CFG_RD && !CFG_WR |=> !CFG_ACK;
  endproperty
  a_no_spurious_ack: assert property (p_no_spurious_ack) else $error("ack without access");

  property p_level_follows;
    1'b1 |=> FUNCTION_POWER_LEVEL == $past(level);
  endproperty
  a_level_follows: assert property (p_level_follows) else $error("power level output lags wrongly");

  property p_level_write_lands;
    s_level_write |=> level == $past(CFG_WDATA[pmc_pkg::POS_LEVEL_MSB:pmc_pkg::POS_LEVEL_LSB]);
  endproperty
  a_level_write_lands: assert property (p_level_write_lands) else $error("power level write lost");

  property p_level_held;
    !level_wr |=> $stable(level);
  endproperty
  a_level_held: assert property (p_level_held) else $error("power level changed without write");

  property p_write_beats_read;
    s_collision |=> CFG_ACK && CFG_RDATA == 32'h0000_0000;
  endproperty
  a_write_beats_read: assert property (p_write_beats_read) else $error("read data on colliding write");

  property p_rdata_idle_zero;
    !is_read |=> CFG_RDATA == 32'h0000_0000;
  endproperty
  a_rdata_idle_zero: assert property (p_rdata_idle_zero) else $error("read data outside a read");

  property p_pm_head_word;
    is_read && CFG_DW_ADDR == pmc_pkg::DW_PM_HEAD |=> CFG_ACK && CFG_RDATA == 32'h0000_7001;
  endproperty
  a_pm_head_word: assert property (p_pm_head_word) else $error("pm head dword wrong");

endmodule

//--- rtl/pmc_pkg.sv
package pmc_pkg;

  // configuration byte offsets
  localparam logic [7:0] OFF_PM_CAP_ID = 8'h50;
  localparam logic [7:0] OFF_PM_NEXT = 8'h51;
  localparam logic [7:0] OFF_CSR = 8'h54;
  localparam logic [7:0] OFF_BSE = 8'h56;
  localparam logic [7:0] OFF_PM_DATA = 8'h57;
  localparam logic [7:0] OFF_MSI_ID = 8'h70;
  localparam logic [7:0] OFF_MSI_NEXT = 8'h71;

  // dword indices seen on the access port
  localparam logic [5:0] DW_PM_HEAD = OFF_PM_CAP_ID[7:2];
  localparam logic [5:0] DW_CSR = OFF_CSR[7:2];
  localparam logic [5:0] DW_MSI_HEAD = OFF_MSI_ID[7:2];

  // byte lanes inside a dword
  localparam int LANE_PM_NEXT = 1;
  localparam int LANE_CSR_LO = 0;
  localparam int LANE_BSE = 2;
  localparam int LANE_PM_DATA = 3;
  localparam int LANE_MSI_ID = 0;
  localparam int LANE_MSI_NEXT = 1;

  // read values and reset values
  localparam logic [7:0] VAL_PM_CAP_ID = 8'h01;
  localparam logic [7:0] VAL_PM_NEXT = 8'h70;
  localparam logic [15:0] RST_CSR = 16'h0008;
  localparam logic [7:0] VAL_BSE = 8'h00;
  localparam logic [7:0] VAL_PM_DATA = 8'h00;
  localparam logic [7:0] VAL_MSI_ID = 8'h05;
  localparam logic [7:0] VAL_MSI_NEXT = 8'h80;

  // control/status field positions
  localparam int POS_LEVEL_LSB = 0;
  localparam int POS_LEVEL_MSB = 1;
  localparam int POS_NO_SOFT_RST = 3;
  localparam int POS_EVENT_EN = 8;
  localparam int POS_EVENT_STAT = 15;

  localparam logic [1:0] LEVEL_D0 = 2'h0;
  localparam logic [1:0] LEVEL_D1 = 2'h1;
  localparam logic [1:0] LEVEL_D2 = 2'h2;
  localparam logic [1:0] LEVEL_D3HOT = 2'h3;
  localparam logic [1:0] RST_LEVEL = LEVEL_D0;

endpackage

//--- rtl/pmc_power_level.sv
// holds the writable function power level field
module pmc_power_level (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [1:0] wr_level,
  output logic [1:0] function_power_level
);

  always_ff @(posedge clk) begin
    if (rst) begin
      function_power_level <= pmc_pkg::RST_LEVEL;
    end else if (wr_en) begin
      function_power_level <= wr_level;
    end
  end

endmodule

//--- testbench/pmc_cap_regs_bench.sv
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pmc_cap_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cfg_rd = 1'b0;
  logic cfg_wr = 1'b0;
  logic [5:0] cfg_dw_addr = 6'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [31:0] cfg_rdata;
  logic cfg_ack;
  logic [1:0] function_power_level;
  int miscompares = 0;
  int samples_checked = 0;

  pmc_cap_regs dut (
    .CLK_SYS(clk_sys),
    .RESET(reset),
    .CFG_RD(cfg_rd),
    .CFG_WR(cfg_wr),
    .CFG_DW_ADDR(cfg_dw_addr),
    .CFG_BE(cfg_be),
    .CFG_WDATA(cfg_wdata),
    .CFG_RDATA(cfg_rdata),
    .CFG_ACK(cfg_ack),
    .FUNCTION_POWER_LEVEL(function_power_level)
  );

  always #25 clk_sys = ~clk_sys;

  task automatic do_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (10) @(posedge clk_sys);
    // first read taken at the first edge with reset low
    reset <= 1'b0;
    cfg_rd <= 1'b1;
    cfg_dw_addr <= pmc_pkg::DW_CSR;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1;
    `CHK(cfg_ack, 1'b1);
    `CHK(cfg_rdata, 32'h0000_0008);
    `CHK(function_power_level, pmc_pkg::LEVEL_D0);
  endtask

  // one read, ack and data judged in the answer cycle
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    cfg_rd <= 1'b1;
    cfg_dw_addr <= a;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1;
    `CHK(cfg_ack, 1'b1);
    `CHK(cfg_rdata, exp);
  endtask

  task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_dw_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    #1;
    `CHK(cfg_ack, 1'b1);
  endtask

  task automatic t_reset_values();
    `CHK(function_power_level, pmc_pkg::LEVEL_D0);
    rd_chk(pmc_pkg::DW_CSR, 32'h0000_0008);
    rd_chk(pmc_pkg::DW_PM_HEAD, 32'h0000_7001);
    rd_chk(pmc_pkg::DW_MSI_HEAD, 32'h0000_8005);
  endtask

  // every level, with ones pushed into all hardwired bits
  task automatic t_levels();
    for (int i = 0; i < 4; i++) begin
      wr(pmc_pkg::DW_CSR, 4'hf, 32'hffff_fffc | 32'(i));
      rd_chk(pmc_pkg::DW_CSR, 32'h0000_0008 | 32'(i));
      `CHK(function_power_level, 2'(i));
    end
    wr(pmc_pkg::DW_CSR, 4'he, 32'hffff_fff1);
    rd_chk(pmc_pkg::DW_CSR, 32'h0000_000b);
  endtask

  task automatic t_readonly_writes();
    wr(pmc_pkg::DW_MSI_HEAD, 4'hf, 32'hffff_ffff);
    rd_chk(pmc_pkg::DW_MSI_HEAD, 32'h0000_8005);
    wr(pmc_pkg::DW_PM_HEAD, 4'hf, 32'h0000_0000);
    rd_chk(pmc_pkg::DW_PM_HEAD, 32'h0000_7001);
  endtask

  // write then read in consecutive cycles
  task automatic t_back_to_back();
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_dw_addr <= pmc_pkg::DW_CSR;
    cfg_be <= 4'hf;
    cfg_wdata <= 32'hffff_fffe;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b1;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1;
    `CHK(cfg_ack, 1'b1);
    `CHK(cfg_rdata, 32'h0000_000a);
    `CHK(function_power_level, pmc_pkg::LEVEL_D2);
  endtask

  // write wins over a same-cycle read; unmapped dwords inert
  task automatic t_collide_unmapped();
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_rd <= 1'b1;
    cfg_dw_addr <= pmc_pkg::DW_CSR;
    cfg_be <= 4'h1;
    cfg_wdata <= 32'h0000_0001;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1;
    `CHK(cfg_ack, 1'b1);
    `CHK(cfg_rdata, 32'h0000_0000);
    rd_chk(pmc_pkg::DW_CSR, 32'h0000_0009);
    wr(6'h3f, 4'hf, 32'hffff_ffff);
    rd_chk(6'h3f, 32'h0000_0000);
    rd_chk(pmc_pkg::DW_CSR, 32'h0000_0009);
  endtask

  task automatic t_mid_reset();
    wr(pmc_pkg::DW_CSR, 4'h1, 32'h0000_0002);
    do_reset();
    rd_chk(pmc_pkg::DW_CSR, 32'h0000_0008);
    `CHK(function_power_level, pmc_pkg::LEVEL_D0);
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    do_reset();
    t_reset_values();
    t_levels();
    t_readonly_writes();
    t_back_to_back();
    t_collide_unmapped();
    t_mid_reset();
    conclude();
  end

  initial begin
    repeat (2000) @(posedge clk_sys);
    miscompares++;
    conclude();
  end
endmodule
